// ---- rtl/scct_host.sv ----
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ns
`include "scct_params.svh"
module scct_host (
    input  wire logic  clk_sys,
    input  wire logic  rst_n,
    input  wire logic  hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic  hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic  hready,
    output logic       hreadyout,
    output logic       hresp,
    output logic [31:0] hrdata,
    scct_if.host       bus
);
    localparam logic [4:0] QUARTER = 5'(`SCCT_QUARTER_CYCLES - 1);
    logic [1:0] meta;
    logic [1:0] sync;
    logic       sda_v;
    logic       wr_pend;
    logic [7:0] addr_q;
    logic       go;
    logic       is_read;
    logic [7:0] cmd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic       done;
    logic       nack;
    logic [4:0] div;
    logic       tick;
    logic [1:0] q;
    logic [2:0] bi;
    logic [3:0] bn;
    logic [7:0] rx;
    logic [7:0] tx_byte;
    logic       master_tx;
    logic       drive_low;
    logic       scl_low;
    logic       sda_low;
    logic       busy;
    scct_pkg::scct_host_state_type state;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta <= 2'h3;
            sync <= 2'h3;
        end else begin
            meta <= {bus.scl, bus.sda};
            sync <= meta;
        end
    end
    assign sda_v = sync[0];
    assign busy  = state != scct_pkg::h_idle;

    // zero-wait slave: read data registered in the address phase
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_pend <= 1'h0;
            addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            wr_pend <= hsel & htrans[1] & hwrite;
            addr_q <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite) begin
                unique case (haddr[7:0])
                    `SCCT_REG_CTRL:   hrdata <= {30'h0000_0000, is_read, 1'h0};
                    `SCCT_REG_CMD:    hrdata <= {24'h00_0000, cmd};
                    `SCCT_REG_WDATA:  hrdata <= {16'h0000, wdata};
                    `SCCT_REG_STATUS: hrdata <= {29'h0000_0000, nack, done, busy};
                    `SCCT_REG_RDATA:  hrdata <= {16'h0000, rdata};
                    default:          hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign hreadyout = 1'h1;
    assign hresp     = 1'h0;

    // a start request while busy is ignored
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            go <= 1'h0;
            is_read <= 1'h0;
            cmd <= 8'h00;
            wdata <= 16'h0000;
        end else begin
            go <= wr_pend && addr_q == `SCCT_REG_CTRL && hwdata[`SCCT_CTRL_GO] && !busy;
            if (wr_pend && !busy) begin
                if (addr_q == `SCCT_REG_CTRL) begin
                    is_read <= hwdata[`SCCT_CTRL_READ];
                end
                if (addr_q == `SCCT_REG_CMD) begin
                    cmd <= hwdata[7:0];
                end
                if (addr_q == `SCCT_REG_WDATA) begin
                    wdata <= hwdata[15:0];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !busy || div == QUARTER) begin
            div <= 5'h00;
        end else begin
            div <= div + 5'h01;
        end
    end
    assign tick = busy && div == QUARTER;

    always_comb begin
        unique case (bi)
            3'h0:    tx_byte = {`SCCT_TARGET_ADDR, 1'h0};
            3'h1:    tx_byte = cmd;
            3'h2:    tx_byte = is_read ? {`SCCT_TARGET_ADDR, 1'h1} : wdata[7:0];
            3'h3:    tx_byte = wdata[15:8];
            default: tx_byte = 8'h00;
        endcase
    end
    assign master_tx = !(is_read && bi >= 3'h3);
    assign drive_low = (bn < `SCCT_BIT_ACK) ? (master_tx & ~tx_byte[~bn[2:0]])
                                            : (is_read && bi == 3'h3);

    // each bit is four quarters: set sda, raise scl, sample, lower scl
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= scct_pkg::h_idle;
            q <= 2'h0;
            bi <= 3'h0;
            bn <= 4'h0;
            scl_low <= 1'h0;
            sda_low <= 1'h0;
            rx <= 8'h00;
            rdata <= 16'h0000;
            done <= 1'h0;
            nack <= 1'h0;
        end else if (state == scct_pkg::h_idle) begin
            if (go) begin
                state <= scct_pkg::h_start;
                q <= 2'h0;
                bi <= 3'h0;
                done <= 1'h0;
                nack <= 1'h0;
            end
        end else if (tick) begin
            q <= q + 2'h1;
            unique case (state)
                scct_pkg::h_start: begin
                    unique case (q)
                        2'h0: sda_low <= 1'h0;
                        2'h1: scl_low <= 1'h0;
                        2'h2: sda_low <= 1'h1;
                        2'h3: begin
                            scl_low <= 1'h1;
                            bn <= 4'h0;
                            state <= scct_pkg::h_bit;
                        end
                    endcase
                end
                scct_pkg::h_bit: begin
                    unique case (q)
                        2'h0: sda_low <= drive_low;
                        2'h1: scl_low <= 1'h0;
                        2'h2: begin
                            if (bn < `SCCT_BIT_ACK) begin
                                rx <= {rx[6:0], sda_v};
                            end else if (master_tx && sda_v) begin
                                nack <= 1'h1;
                            end
                        end
                        2'h3: begin
                            scl_low <= 1'h1;
                            bn <= bn + 4'h1;
                            if (bn == `SCCT_BIT_ACK) begin
                                bn <= 4'h0;
                                if (is_read && bi == 3'h3) begin
                                    rdata[7:0] <= rx;
                                end
                                if (is_read && bi == 3'h4) begin
                                    rdata[15:8] <= rx;
                                end
                                bi <= bi + 3'h1;
                                if (nack || bi == (is_read ? 3'h4 : 3'h3)) begin
                                    state <= scct_pkg::h_stop;
                                end else if (is_read && bi == 3'h1) begin
                                    state <= scct_pkg::h_start;
                                end
                            end
                        end
                    endcase
                end
                scct_pkg::h_stop: begin
                    unique case (q)
                        2'h0: sda_low <= 1'h1;
                        2'h1: scl_low <= 1'h0;
                        2'h2: sda_low <= 1'h0;
                        2'h3: begin
                            done <= 1'h1;
                            state <= scct_pkg::h_idle;
                        end
                    endcase
                end
                default: ;
            endcase
        end
    end

    assign bus.host_scl_o    = 1'h0;
    assign bus.host_scl_oe_n = ~scl_low;
    assign bus.host_sda_o    = 1'h0;
    assign bus.host_sda_oe_n = ~sda_low;
endmodule

// ---- rtl/scct_if.sv ----
`timescale 1ns/1ns
interface scct_if;
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic scl;
    logic sda;
    // open-drain wired and with pull-up
    assign scl = host_scl_oe_n | host_scl_o;
    assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
    modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
                  output host_sda_o, output host_sda_oe_n);
endinterface

// ---- rtl/scct_params.svh ----
`ifndef SCCT_PARAMS_SVH
`define SCCT_PARAMS_SVH
`define SCCT_TARGET_ADDR    7'h09
`define SCCT_CMD_OPTION     8'h12
`define SCCT_CMD_AMPS       8'h14
`define SCCT_CMD_VOLTS      8'h15
`define SCCT_CMD_SUPPLY     8'h3f
`define SCCT_CMD_MAKER      8'hfe
`define SCCT_CMD_PART       8'hff
`define SCCT_RST_OPTION     16'h7904
`define SCCT_RST_AMPS       16'h0000
`define SCCT_RST_VOLTS      16'h0000
`define SCCT_RST_SUPPLY     16'h1000
`define SCCT_BIT_ACK        4'h8
`define SCCT_BIT_END        4'h9
`define SCCT_CLK_PERIOD_NS  100
`define SCCT_SCL_PERIOD_NS  10000
`define SCCT_QUARTER_CYCLES (`SCCT_SCL_PERIOD_NS / (4 * `SCCT_CLK_PERIOD_NS))
`define SCCT_REG_CTRL       8'h00
`define SCCT_REG_CMD        8'h04
`define SCCT_REG_WDATA      8'h08
`define SCCT_REG_STATUS     8'h0c
`define SCCT_REG_RDATA      8'h10
`define SCCT_CTRL_GO        0
`define SCCT_CTRL_READ      1
`define SCCT_STAT_BUSY      0
`define SCCT_STAT_DONE      1
`define SCCT_STAT_NACK      2
`endif

// ---- rtl/scct_pkg.sv ----
package scct_pkg;
    typedef enum logic [2:0] {
        st_idle, st_addr, st_cmd, st_wr_lo, st_wr_hi, st_rd_lo, st_rd_hi, st_done
    } scct_dev_state_type;
    typedef enum logic [1:0] {h_idle, h_start, h_bit, h_stop} scct_host_state_type;
endpackage

// ---- rtl/scct_target.sv ----
`timescale 1ns/1ns
`include "scct_params.svh"
module scct_target #(
    parameter logic [15:0] MAKER_ID = 16'h5a5a, // arbitrary value
    parameter logic [15:0] PART_ID  = 16'h0c3c  // arbitrary value
) (
    input  wire logic  clk_sys,
    input  wire logic  rst_n,
    input  wire logic  supply_above_undervoltage_lockout_level,
    input  wire logic  adapter_detect_level,
    scct_if.dev        bus,
    output logic [15:0] charger_option_bits,
    output logic [15:0] charging_amps_limit,
    output logic [15:0] pack_voltage_target,
    output logic [15:0] supply_draw_limit
);
    logic [3:0] meta;
    logic [3:0] sync;
    logic       scl_p;
    logic       sda_p;
    logic       scl_v;
    logic       sda_v;
    logic       comm_en;
    logic       start_c;
    logic       stop_c;
    logic       scl_rise;
    logic       scl_fall;
    logic       active;
    logic       addr_hit;
    logic       rx_ack;
    logic       master_ack;
    logic       sda_low;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] cmd;
    logic [7:0] lo_byte;
    logic [7:0] tx_byte;
    logic [15:0] read_word;
    scct_pkg::scct_dev_state_type state;
    scct_pkg::scct_dev_state_type next_state;

    // pins are asynchronous, two stages before any use
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // bus lines rest high, so no false edge follows reset
            meta <= 4'hc;
            sync <= 4'hc;
            scl_p <= 1'h1;
            sda_p <= 1'h1;
        end else begin
            meta <= {bus.scl, bus.sda, supply_above_undervoltage_lockout_level, adapter_detect_level};
            sync <= meta;
            scl_p <= sync[3];
            sda_p <= sync[2];
        end
    end

    assign scl_v    = sync[3];
    assign sda_v    = sync[2];
    assign comm_en  = sync[1] & sync[0];
    assign start_c  = scl_v & scl_p & sda_p & ~sda_v;
    assign stop_c   = scl_v & scl_p & ~sda_p & sda_v;
    assign scl_rise = scl_v & ~scl_p;
    assign scl_fall = ~scl_v & scl_p;
    assign active   = (state != scct_pkg::st_idle) && (state != scct_pkg::st_done);
    assign addr_hit = shift[7:1] == `SCCT_TARGET_ADDR;

    always_comb begin
        unique case (cmd)
            `SCCT_CMD_OPTION: read_word = charger_option_bits;
            `SCCT_CMD_AMPS:   read_word = charging_amps_limit;
            `SCCT_CMD_VOLTS:  read_word = pack_voltage_target;
            `SCCT_CMD_SUPPLY: read_word = supply_draw_limit;
            `SCCT_CMD_MAKER:  read_word = MAKER_ID;
            `SCCT_CMD_PART:   read_word = PART_ID;
            default:          read_word = 16'h0000;
        endcase
    end

    assign tx_byte = (state == scct_pkg::st_rd_hi) ? read_word[15:8] : read_word[7:0];

    always_comb begin
        unique case (state)
            // a foreign address drops back to idle until the next start
            scct_pkg::st_addr:  next_state = addr_hit ? (shift[0] ? scct_pkg::st_rd_lo : scct_pkg::st_cmd)
                                                      : scct_pkg::st_idle;
            scct_pkg::st_cmd:   next_state = scct_pkg::st_wr_lo;
            scct_pkg::st_wr_lo: next_state = scct_pkg::st_wr_hi;
            scct_pkg::st_wr_hi: next_state = scct_pkg::st_done;
            scct_pkg::st_rd_lo: next_state = master_ack ? scct_pkg::st_rd_hi : scct_pkg::st_done;
            scct_pkg::st_rd_hi: next_state = scct_pkg::st_done;
            scct_pkg::st_idle:  next_state = scct_pkg::st_idle;
            scct_pkg::st_done:  next_state = scct_pkg::st_done;
        endcase
    end

    // acknowledge only in receiving states
    always_comb begin
        unique case (state)
            scct_pkg::st_addr:  rx_ack = addr_hit;
            scct_pkg::st_cmd:   rx_ack = 1'h1;
            scct_pkg::st_wr_lo: rx_ack = 1'h1;
            scct_pkg::st_wr_hi: rx_ack = 1'h1;
            default:            rx_ack = 1'h0;
        endcase
    end

    // byte sequencing; a start from any state restarts address reception
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !comm_en) begin
            state <= scct_pkg::st_idle;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            master_ack <= 1'h0;
        end else if (start_c) begin
            state <= scct_pkg::st_addr;
            bit_cnt <= 4'h0;
        end else if (stop_c) begin
            state <= scct_pkg::st_idle;
            bit_cnt <= 4'h0;
        end else if (active) begin
            if (scl_rise) begin
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt < `SCCT_BIT_ACK) begin
                    shift <= {shift[6:0], sda_v};
                end
                if (bit_cnt == `SCCT_BIT_ACK) begin
                    master_ack <= ~sda_v;
                end
            end else if (scl_fall && bit_cnt == `SCCT_BIT_END) begin
                bit_cnt <= 4'h0;
                state <= next_state;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cmd <= 8'h00;
            lo_byte <= 8'h00;
        end else if (active && scl_fall && bit_cnt == `SCCT_BIT_END) begin
            if (state == scct_pkg::st_cmd) begin
                cmd <= shift;
            end
            if (state == scct_pkg::st_wr_lo) begin
                lo_byte <= shift;
            end
        end
    end

    // word commits after the high byte; identification words have no storage
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            charger_option_bits <= `SCCT_RST_OPTION;
            charging_amps_limit <= `SCCT_RST_AMPS;
            pack_voltage_target <= `SCCT_RST_VOLTS;
            supply_draw_limit <= `SCCT_RST_SUPPLY;
        end else if (comm_en && active && scl_fall && bit_cnt == `SCCT_BIT_END
                     && state == scct_pkg::st_wr_hi) begin
            unique case (cmd)
                `SCCT_CMD_OPTION: charger_option_bits <= {shift, lo_byte};
                `SCCT_CMD_AMPS:   charging_amps_limit <= {shift, lo_byte};
                `SCCT_CMD_VOLTS:  pack_voltage_target <= {shift, lo_byte};
                `SCCT_CMD_SUPPLY: supply_draw_limit <= {shift, lo_byte};
                default: ;
            endcase
        end
    end

    // sda moves only on a falling scl, or is released on start, stop, leaving active states or comm_en dropping; stable in each high phase while enabled
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !comm_en || start_c || stop_c || !active) begin
            sda_low <= 1'h0;
        end else if (scl_fall) begin
            if (bit_cnt == `SCCT_BIT_ACK) begin
                sda_low <= rx_ack;
            end else if (bit_cnt == `SCCT_BIT_END) begin
                if (next_state == scct_pkg::st_rd_lo) begin
                    sda_low <= ~read_word[7];
                end else if (next_state == scct_pkg::st_rd_hi) begin
                    sda_low <= ~read_word[15];
                end else begin
                    sda_low <= 1'h0;
                end
            end else if ((state == scct_pkg::st_rd_lo || state == scct_pkg::st_rd_hi)
                         && bit_cnt != 4'h0) begin
                sda_low <= ~tx_byte[~bit_cnt[2:0]];
            end
        end
    end

    // only sda is ever driven; scl has no driver here
    assign bus.dev_sda_o    = 1'h0;
    assign bus.dev_sda_oe_n = ~sda_low;
endmodule

// ---- test/scct_properties.sv ----
`timescale 1ns/1ns
module scct_properties (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic host_scl_o,
    input wire logic host_scl_oe_n,
    input wire logic host_sda_o,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // the wire levels are sampled on the system clock, so each phase spans many samples
    chk_dev_low_phase: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("device sda moved while scl high");
    chk_start_by_host: assert property (($fell(sda) && scl && $past(scl)) |-> dev_sda_oe_n && !host_sda_oe_n)
        else $error("start not made by host alone");
    chk_high_change_host: assert property (($changed(sda) && scl && $past(scl)) |-> $changed(host_sda_oe_n))
        else $error("sda moved in scl high without host");
    chk_dev_drive_late: assert property ($fell(dev_sda_oe_n) |-> !scl && !$past(scl))
        else $error("device took sda outside scl low");
    chk_stop_releases: assert property (($rose(sda) && scl && $past(scl)) |=> dev_sda_oe_n [*8])
        else $error("device drove sda after stop");
    chk_scl_high_span: assert property ($rose(scl) |-> scl [*8])
        else $error("scl high phase too short");
    chk_scl_low_span: assert property ($fell(scl) |-> !scl [*8])
        else $error("scl low phase too short");
    chk_dev_bit_hold: assert property (($rose(scl) && !dev_sda_oe_n) |-> !dev_sda_oe_n [*8])
        else $error("device bit not held in scl high");
    chk_host_bit_hold: assert property ($rose(scl) |-> $stable(host_sda_oe_n) [*8])
        else $error("host bit not held after scl rise");
    cover property ($fell(sda) && scl);
    cover property ($rose(sda) && scl);
    cover property ($rose(scl) && !dev_sda_oe_n);
endmodule

// ---- test/smbus_charger_command_target_bench.sv ----
`timescale 1ns/1ns
`include "scct_params.svh"
module smbus_charger_command_target_bench;
    localparam logic [15:0] MAKER = 16'h3c5a; // arbitrary value
    localparam logic [15:0] PART  = 16'h0a69; // arbitrary value
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        supply_ok = 1'b1;
    logic        adapter_ok = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    wire  [15:0] opt;
    wire  [15:0] amps;
    wire  [15:0] volts;
    wire  [15:0] sup;
    int          fails = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          nb = -1;
    logic        sp = 1'b1;
    logic        sl = 1'b1;
    logic [8:0]  sh = 9'h000;
    scct_if i_scct_if ();
    scct_target #(.MAKER_ID(MAKER), .PART_ID(PART)) i_scct_target (.clk_sys(clk_sys), .rst_n(rst_n),
        .supply_above_undervoltage_lockout_level(supply_ok), .adapter_detect_level(adapter_ok), .bus(i_scct_if.dev),
        .charger_option_bits(opt), .charging_amps_limit(amps), .pack_voltage_target(volts),
        .supply_draw_limit(sup));
    scct_host i_scct_host (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .bus(i_scct_if.host));
    scct_properties i_scct_properties (.clk_sys(clk_sys), .rst_n(rst_n), .scl(i_scct_if.scl),
        .sda(i_scct_if.sda), .host_scl_o(i_scct_if.host_scl_o), .host_scl_oe_n(i_scct_if.host_scl_oe_n),
        .host_sda_o(i_scct_if.host_sda_o), .host_sda_oe_n(i_scct_if.host_sda_oe_n),
        .dev_sda_o(i_scct_if.dev_sda_o), .dev_sda_oe_n(i_scct_if.dev_sda_oe_n));
    always #50 clk_sys = ~clk_sys;
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("fails=%0d check_count=%0d", fails, check_count);
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // a hung transfer must still reach the report
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            fails++;
            tally_and_finish();
        end
    end
    // first byte after each start seen on the wire, with its ack slot
    always @(posedge clk_sys) begin
        sp <= i_scct_if.scl;
        sl <= i_scct_if.sda;
        if (i_scct_if.scl && sp && sl && !i_scct_if.sda) begin
            nb <= 0;
        end else if (i_scct_if.scl && !sp && nb >= 0 && nb < 9) begin
            sh <= {sh[7:0], i_scct_if.sda};
            nb <= nb + 1;
        end else if (nb == 9) begin
            compare({24'h00_0000, sh[8:1] | 8'h01}, 32'h0000_0013);
            compare({31'h0000_0000, sh[0]}, {31'h0000_0000, ~(supply_ok & adapter_ok)});
            nb <= -1;
        end
    end
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic smb(input logic r, input logic [7:0] c, input logic [15:0] w, output logic [31:0] st,
                       output logic [31:0] rw);
        int          n;
        logic [31:0] x;
        ahb(1'b1, `SCCT_REG_CMD, {24'h00_0000, c}, x);
        ahb(1'b1, `SCCT_REG_WDATA, {16'h0000, w}, x);
        ahb(1'b1, `SCCT_REG_CTRL, {30'h0000_0000, r, 1'b1}, x);
        n = 0;
        st = 32'h0000_0000;
        while (st[`SCCT_STAT_DONE] !== 1'b1 && n < 4000) begin
            ahb(1'b0, `SCCT_REG_STATUS, 32'h0000_0000, st);
            n++;
        end
        ahb(1'b0, `SCCT_REG_RDATA, 32'h0000_0000, rw);
    endtask
    function automatic logic [15:0] port_of(input int i);
        case (i)
            0: port_of = opt;
            1: port_of = amps;
            2: port_of = volts;
            default: port_of = sup;
        endcase
    endfunction
    task automatic test_word_rw;
        logic [7:0]  cmds [4] = '{`SCCT_CMD_OPTION, `SCCT_CMD_AMPS, `SCCT_CMD_VOLTS, `SCCT_CMD_SUPPLY};
        logic [15:0] d;
        logic [31:0] st;
        logic [31:0] rw;
        // asymmetric words expose byte swaps and bit order
        for (int i = 0; i < 4; i++) begin
            d = 16'h81c3 + 16'h1011 * 16'(i);
            smb(1'b0, cmds[i], d, st, rw);
            compare({29'h0000_0000, st[2:0]}, 32'h0000_0002);
            compare({16'h0000, port_of(i)}, {16'h0000, d});
            smb(1'b1, cmds[i], 16'h0000, st, rw);
            compare({16'h0000, rw[15:0]}, {16'h0000, d});
        end
    endtask
    task automatic test_ids;
        logic [31:0] st;
        logic [31:0] rw;
        smb(1'b0, `SCCT_CMD_MAKER, 16'hffff, st, rw);
        smb(1'b1, `SCCT_CMD_MAKER, 16'h0000, st, rw);
        compare({16'h0000, rw[15:0]}, {16'h0000, MAKER});
        smb(1'b1, `SCCT_CMD_PART, 16'h0000, st, rw);
        compare({16'h0000, rw[15:0]}, {16'h0000, PART});
    endtask
    task automatic test_disabled;
        logic [31:0] st;
        logic [31:0] rw;
        @(posedge clk_sys);
        supply_ok <= 1'b0;
        repeat (8) @(posedge clk_sys);
        smb(1'b0, `SCCT_CMD_AMPS, 16'h0f0f, st, rw);
        compare({31'h0000_0000, st[`SCCT_STAT_NACK]}, 32'h0000_0001);
        compare({16'h0000, amps}, 32'h0000_91d4);
        supply_ok <= 1'b1;
        adapter_ok <= 1'b0;
        repeat (8) @(posedge clk_sys);
        smb(1'b0, `SCCT_CMD_AMPS, 16'h0f0f, st, rw);
        compare({31'h0000_0000, st[`SCCT_STAT_NACK]}, 32'h0000_0001);
        compare({16'h0000, amps}, 32'h0000_91d4);
        adapter_ok <= 1'b1;
        repeat (8) @(posedge clk_sys);
        // qualified again: the word written earlier must read back
        smb(1'b1, `SCCT_CMD_AMPS, 16'h0000, st, rw);
        compare({16'h0000, rw[15:0]}, 32'h0000_91d4);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        compare({opt, amps}, {`SCCT_RST_OPTION, `SCCT_RST_AMPS});
        compare({volts, sup}, {`SCCT_RST_VOLTS, `SCCT_RST_SUPPLY});
        test_word_rw();
        test_ids();
        test_disabled();
        tally_and_finish();
    end
endmodule
